// *** hw/bct_pkg.sv ***
// bct_pkg: shared constants and types of the bcd calendar timekeeper.
// assumes a 32-bit ahb-lite register bus, one word per register.
package bct_pkg;

   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_YEAR    = 8'h04;
   localparam logic [7:0] OFS_MONTH   = 8'h08;
   localparam logic [7:0] OFS_DAY     = 8'h0C;
   localparam logic [7:0] OFS_WEEKDAY = 8'h10;
   localparam logic [7:0] OFS_HOURS   = 8'h14;
   localparam logic [7:0] OFS_MINUTES = 8'h18;
   localparam logic [7:0] OFS_SECONDS = 8'h1C;

   // -----------------------------------------------------------------
   // control register fields
   // -----------------------------------------------------------------
   localparam int CTL_RUN    = 7;
   localparam int CTL_UNLOCK = 5;
   localparam int CTL_WARN   = 4;
   localparam int CTL_HALF   = 3;
   localparam int CTL_SEL_LO = 0;
   localparam int CTL_SEL_HI = 1;

   // clock source selection codes
   localparam logic [1:0] SEL_XTAL = 2'h0;
   localparam logic [1:0] SEL_MID  = 2'h1;
   localparam logic [1:0] SEL_Z50  = 2'h2;
   localparam logic [1:0] SEL_Z60  = 2'h3;

   // -----------------------------------------------------------------
   // prescaler terminal counts (divide ratio minus one) and warn lead
   // -----------------------------------------------------------------
   localparam logic [13:0] TERM_XTAL = 14'h3FFF;
   localparam logic [13:0] TERM_MID  = 14'h3D08;
   localparam logic [13:0] TERM_Z50  = 14'h0018;
   localparam logic [13:0] TERM_Z60  = 14'h001D;
   localparam logic [14:0] WARN_OSC  = 15'h0020;
   localparam logic [14:0] WARN_LINE = 15'h0001;

   // -----------------------------------------------------------------
   // bcd limits, field masks and reset values
   // -----------------------------------------------------------------
   localparam logic [3:0] DIGIT_NINE = 4'h9;
   localparam logic [7:0] BCD_ZERO   = 8'h00;
   localparam logic [7:0] BCD_ONE    = 8'h01;
   localparam logic [7:0] MAX_SEC    = 8'h59;
   localparam logic [7:0] MAX_HOUR   = 8'h23;
   localparam logic [7:0] MAX_WDAY   = 8'h06;
   localparam logic [7:0] MAX_MONTH  = 8'h12;
   localparam logic [7:0] MAX_YEAR   = 8'h99;
   localparam logic [7:0] DAYS_31    = 8'h31;
   localparam logic [7:0] DAYS_30    = 8'h30;
   localparam logic [7:0] DAYS_29    = 8'h29;
   localparam logic [7:0] DAYS_28    = 8'h28;
   localparam logic [7:0] MON_FEB    = 8'h02;
   localparam logic [7:0] MON_APR    = 8'h04;
   localparam logic [7:0] MON_JUN    = 8'h06;
   localparam logic [7:0] MON_SEP    = 8'h09;
   localparam logic [7:0] MON_NOV    = 8'h11;
   localparam logic [7:0] MASK_SEC   = 8'h7F;
   localparam logic [7:0] MASK_HOUR  = 8'h3F;
   localparam logic [7:0] MASK_WDAY  = 8'h07;
   localparam logic [7:0] MASK_DAY   = 8'h3F;
   localparam logic [7:0] MASK_MONTH = 8'h1F;
   localparam logic [7:0] MASK_YEAR  = 8'hFF;
   localparam logic [7:0] RST_WDAY   = 8'h06;

   // calendar value as carried on the time output
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] weekday;
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
   } bct_time_t;

endpackage

// *** hw/bct_timekeeper.sv ***
// bct_timekeeper: bcd calendar timekeeper with ahb-lite register slave.
// assumes slow source inputs are synchronous levels of the bus clock
// and that the crystal-ready input is high once the crystal runs.
//
// Operation
// - calendar spans 2000-01-01 00:00:00 to 2099-12-31 23:59:59
// - hours count 00 to 23 only, no twelve-hour mode
// - half-second bit is read-only, cleared by seconds write, reset or each second tick
// - time and date registers hold two bcd digits, except weekday which holds one (0 to 6)
// - software writes load counters, counting resumes from them
// - time counts only while run-enable bit 7 is set
// - counting goes on during writes; seconds write clears prescaler
// - writes land in the write cycle; software avoids carry moments
// - time value writes take effect only while unlock is set
// - run-enable write ignored unless unlock bit is one
// - run-enable reads set only once the oscillator is running
// - crystal source divided by 16384 for half-second tick
// - internal 31.25 khz source divided by 15625
// - line source divided by 25 at 50 hz, 30 at 60 hz
// - 23:59:59 rolls to 00:00:00 carrying into day and weekday
// - december 31 rolls to january 01, carrying into year
// - year wraps from 99 to 00
// - lower bcd digit carries into upper at ten
// - day limit is 31 or 30 by month, february special
// - february has 29 days when year divisible by four
// - rollover warning set edges before rollover, cleared at it
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module bct_timekeeper (
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   input  wire logic              hsel_in,
   input  wire logic [31:0]       haddr_in,
   input  wire logic [1:0]        htrans_in,
   input  wire logic              hwrite_in,
   input  wire logic [2:0]        hsize_in,
   input  wire logic [31:0]       hwdata_in,
   input  wire logic              hready_in,
   output logic [31:0]            hrdata_out,
   output logic                   hreadyout_out,
   output logic                   hresp_out,
   input  wire logic              xtal_clk_in,
   input  wire logic              xtal_ready_in,
   input  wire logic              mid_clk_in,
   input  wire logic              line_clk_in,
   output logic                   half_sec_out,
   output bct_pkg::bct_time_t     time_out
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   bct_pkg::bct_time_t tm_ff;
   logic              run_req_ff;
   logic              rtc_run_enable_ff;
   logic              timer_write_unlock_ff;
   logic [1:0]        sel_ff;
   logic [13:0]       pre_ff;
   logic              half_ff;
   logic              rollover_warning_ff;
   logic [2:0]        src_prev_ff;
   logic              dph_wr_ff;
   logic [7:0]        dph_addr_ff;
   logic [31:0]       hrdata_ff;

   logic              src_edge;
   logic [13:0]       term;
   logic [14:0]       warn_lead;
   logic              half_tick;
   logic              sec_tick;
   logic              addr_ok;
   logic              wr_now;
   logic [7:0]        wval;
   logic              tm_wr;
   logic              nxt_warn;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // two-digit bcd step, wrapping to lo after hi
   function automatic logic [7:0] bcd_step(input logic [7:0] v,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
      logic [7:0] r;
      r = v;
      if (v >= hi) begin
         r = lo;
      end else if (v[3:0] >= bct_pkg::DIGIT_NINE) begin
         r = {v[7:4] + 4'h1, 4'h0};
      end else begin
         r = {v[7:4], v[3:0] + 4'h1};
      end
      return r;
   endfunction

   // year divisible by four, on the bcd digits directly
   function automatic logic is_leap(input logic [7:0] y);
      logic ok;
      ok = 1'b0;
      if (y[4] == 1'b0) begin
         ok = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end else begin
         ok = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
      return ok;
   endfunction

   // last day of the current month
   function automatic logic [7:0] last_day(input logic [7:0] m,
                                           input logic [7:0] y);
      logic [7:0] d;
      d = bct_pkg::DAYS_31;
      if (m == bct_pkg::MON_FEB) begin
         d = is_leap(y) ? bct_pkg::DAYS_29 : bct_pkg::DAYS_28;
      end else if (m == bct_pkg::MON_APR || m == bct_pkg::MON_JUN ||
                   m == bct_pkg::MON_SEP || m == bct_pkg::MON_NOV) begin
         d = bct_pkg::DAYS_30;
      end
      return d;
   endfunction

   // -----------------------------------------------------------------
   // clock source selection and prescaler
   // -----------------------------------------------------------------
   // previous levels for edge detection of each slow source
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         src_prev_ff <= 3'h0;
      end else begin
         src_prev_ff <= {line_clk_in, mid_clk_in, xtal_clk_in};
      end
   end

   // per-source edge, divide ratio and warning lead
   always_comb begin
      src_edge  = 1'b0;
      term      = bct_pkg::TERM_XTAL;
      warn_lead = bct_pkg::WARN_OSC;
      case (sel_ff)
         bct_pkg::SEL_XTAL: begin
            src_edge = xtal_clk_in & ~src_prev_ff[0];
            term     = bct_pkg::TERM_XTAL;
         end
         bct_pkg::SEL_MID: begin
            src_edge = mid_clk_in & ~src_prev_ff[1];
            term     = bct_pkg::TERM_MID;
         end
         bct_pkg::SEL_Z50: begin
            src_edge  = line_clk_in & ~src_prev_ff[2];
            term      = bct_pkg::TERM_Z50;
            warn_lead = bct_pkg::WARN_LINE;
         end
         bct_pkg::SEL_Z60: begin
            src_edge  = line_clk_in & ~src_prev_ff[2];
            term      = bct_pkg::TERM_Z60;
            warn_lead = bct_pkg::WARN_LINE;
         end
         default: begin
            src_edge = 1'b0;
         end
      endcase
   end

   assign half_tick = rtc_run_enable_ff & src_edge & (pre_ff >= term);
   assign sec_tick  = half_tick & half_ff;

   // prescaler and half-second bit; a seconds write restarts both
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pre_ff  <= 14'h0000;
         half_ff <= 1'b0;
      end else if (tm_wr && dph_addr_ff == bct_pkg::OFS_SECONDS) begin
         pre_ff  <= 14'h0000;
         half_ff <= 1'b0;
      end else if (half_tick) begin
         pre_ff  <= 14'h0000;
         half_ff <= ~half_ff;
      end else if (rtc_run_enable_ff && src_edge) begin
         pre_ff  <= pre_ff + 14'h0001;
      end
   end

   // -----------------------------------------------------------------
   // rollover warning
   // -----------------------------------------------------------------
   // warn lead before second rollover
   assign nxt_warn = rtc_run_enable_ff & half_ff &
                     (({1'b0, pre_ff} + warn_lead) > {1'b0, term});

   // gone in the cycle after the rollover resets the prescaler
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rollover_warning_ff <= 1'b0;
      end else begin
         rollover_warning_ff <= nxt_warn & ~sec_tick;
      end
   end

   // -----------------------------------------------------------------
   // ahb-lite slave
   // -----------------------------------------------------------------
   // zero-wait slave; only the low address byte is decoded
   assign addr_ok = hsel_in & htrans_in[1] & hready_in;
   assign wr_now  = dph_wr_ff;
   assign wval    = hwdata_in[7:0];
   assign tm_wr   = wr_now & timer_write_unlock_ff &
                    (dph_addr_ff != bct_pkg::OFS_CTRL);

   // capture write address phase
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         dph_wr_ff   <= 1'b0;
         dph_addr_ff <= 8'h00;
      end else begin
         dph_wr_ff   <= addr_ok & hwrite_in;
         dph_addr_ff <= haddr_in[7:0];
      end
   end

   // read data latched in the address phase, shown in the data phase
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (addr_ok && !hwrite_in) begin
         case (haddr_in[7:0])
            bct_pkg::OFS_CTRL: begin
               hrdata_ff <= 32'h0000_0000;
               hrdata_ff[bct_pkg::CTL_RUN]    <= rtc_run_enable_ff;
               hrdata_ff[bct_pkg::CTL_UNLOCK] <= timer_write_unlock_ff;
               hrdata_ff[bct_pkg::CTL_WARN]   <= rollover_warning_ff;
               hrdata_ff[bct_pkg::CTL_HALF]   <= half_ff;
               hrdata_ff[bct_pkg::CTL_SEL_HI:bct_pkg::CTL_SEL_LO] <= sel_ff;
            end
            bct_pkg::OFS_YEAR:    hrdata_ff <= {24'h000000, tm_ff.year};
            bct_pkg::OFS_MONTH:   hrdata_ff <= {24'h000000, tm_ff.month};
            bct_pkg::OFS_DAY:     hrdata_ff <= {24'h000000, tm_ff.day};
            bct_pkg::OFS_WEEKDAY: hrdata_ff <= {24'h000000, tm_ff.weekday};
            bct_pkg::OFS_HOURS:   hrdata_ff <= {24'h000000, tm_ff.hours};
            bct_pkg::OFS_MINUTES: hrdata_ff <= {24'h000000, tm_ff.minutes};
            bct_pkg::OFS_SECONDS: hrdata_ff <= {24'h000000, tm_ff.seconds};
            default:              hrdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign hrdata_out    = hrdata_ff;
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;

   // -----------------------------------------------------------------
   // control register
   // -----------------------------------------------------------------
   // unlock and source select are always writable
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         timer_write_unlock_ff <= 1'b0;
         sel_ff                <= bct_pkg::SEL_XTAL;
         run_req_ff            <= 1'b0;
      end else if (wr_now && dph_addr_ff == bct_pkg::OFS_CTRL) begin
         timer_write_unlock_ff <= hwdata_in[bct_pkg::CTL_UNLOCK];
         sel_ff <= hwdata_in[bct_pkg::CTL_SEL_HI:bct_pkg::CTL_SEL_LO];
         if (timer_write_unlock_ff) begin
            run_req_ff <= hwdata_in[bct_pkg::CTL_RUN];
         end
      end
   end

   // enable set on a source edge; for the crystal source only once the crystal is up
   // clearing takes effect at once so a stop is never delayed
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rtc_run_enable_ff <= 1'b0;
      end else if (!run_req_ff) begin
         rtc_run_enable_ff <= 1'b0;
      end else if (src_edge &&
                   (sel_ff != bct_pkg::SEL_XTAL || xtal_ready_in)) begin
         rtc_run_enable_ff <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // calendar counters
   // -----------------------------------------------------------------
   // reset to 2000-01-01 00:00:00, a saturday
   // write wins over a carry in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         tm_ff.year    <= bct_pkg::BCD_ZERO;
         tm_ff.month   <= bct_pkg::BCD_ONE;
         tm_ff.day     <= bct_pkg::BCD_ONE;
         tm_ff.weekday <= bct_pkg::RST_WDAY;
         tm_ff.hours   <= bct_pkg::BCD_ZERO;
         tm_ff.minutes <= bct_pkg::BCD_ZERO;
         tm_ff.seconds <= bct_pkg::BCD_ZERO;
      end else if (tm_wr) begin
         case (dph_addr_ff)
            bct_pkg::OFS_YEAR:    tm_ff.year    <= wval & bct_pkg::MASK_YEAR;
            bct_pkg::OFS_MONTH:   tm_ff.month   <= wval & bct_pkg::MASK_MONTH;
            bct_pkg::OFS_DAY:     tm_ff.day     <= wval & bct_pkg::MASK_DAY;
            bct_pkg::OFS_WEEKDAY: tm_ff.weekday <= wval & bct_pkg::MASK_WDAY;
            bct_pkg::OFS_HOURS:   tm_ff.hours   <= wval & bct_pkg::MASK_HOUR;
            bct_pkg::OFS_MINUTES: tm_ff.minutes <= wval & bct_pkg::MASK_SEC;
            bct_pkg::OFS_SECONDS: tm_ff.seconds <= wval & bct_pkg::MASK_SEC;
            default: begin
            end
         endcase
      end else if (sec_tick) begin
         tm_ff.seconds <= bcd_step(tm_ff.seconds, bct_pkg::MAX_SEC,
                                   bct_pkg::BCD_ZERO);
         if (tm_ff.seconds >= bct_pkg::MAX_SEC) begin
            tm_ff.minutes <= bcd_step(tm_ff.minutes, bct_pkg::MAX_SEC,
                                      bct_pkg::BCD_ZERO);
            if (tm_ff.minutes >= bct_pkg::MAX_SEC) begin
               tm_ff.hours <= bcd_step(tm_ff.hours, bct_pkg::MAX_HOUR,
                                       bct_pkg::BCD_ZERO);
               if (tm_ff.hours >= bct_pkg::MAX_HOUR) begin
                  tm_ff.weekday <= bcd_step(tm_ff.weekday,
                                            bct_pkg::MAX_WDAY,
                                            bct_pkg::BCD_ZERO);
                  tm_ff.day <= bcd_step(tm_ff.day,
                                        last_day(tm_ff.month, tm_ff.year),
                                        bct_pkg::BCD_ONE);
                  if (tm_ff.day >= last_day(tm_ff.month, tm_ff.year)) begin
                     tm_ff.month <= bcd_step(tm_ff.month,
                                             bct_pkg::MAX_MONTH,
                                             bct_pkg::BCD_ONE);
                     if (tm_ff.month >= bct_pkg::MAX_MONTH) begin
                        tm_ff.year <= bcd_step(tm_ff.year,
                                               bct_pkg::MAX_YEAR,
                                               bct_pkg::BCD_ZERO);
                     end
                  end
               end
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // half bit visible, never writable
   assign half_sec_out = half_ff;
   assign time_out     = tm_ff;

endmodule

// *** tb/bct_timekeeper_properties.sv ***
// bct_timekeeper_properties: port-level checks on the timekeeper.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module bct_timekeeper_checker (
   input  wire logic               ref_clk_in,
   input  wire logic               rst_in,
   input  wire logic               hsel_in,
   input  wire logic [1:0]         htrans_in,
   input  wire logic               hwrite_in,
   input  wire logic               hready_in,
   input  wire logic               hreadyout_out,
   input  wire logic               hresp_out,
   input  wire logic               half_sec_out,
   input  wire bct_pkg::bct_time_t time_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // -----------------------------------------------------------------
   // write tracking
   // -----------------------------------------------------------------
   logic wr_ph_ff;
   // high in a write data phase; the register lands at its closing edge
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wr_ph_ff <= 1'b0;
      end else begin
         wr_ph_ff <= hsel_in & htrans_in[1] & hwrite_in & hready_in;
      end
   end
   AST_ZERO_WAIT: assert property (hreadyout_out && !hresp_out)
      else $error("bus answer not zero-wait okay");
   AST_HOURS_24: assert property (time_out.hours <= 8'h23)
      else $error("hours beyond 23");
   AST_WDAY_RANGE: assert property (time_out.weekday <= 8'h06)
      else $error("weekday beyond 6");
   AST_SEC_STEP: assert property ($changed(time_out.seconds) |->
      $fell(half_sec_out) || $past(wr_ph_ff)) else $error("seconds moved off a tick");
   AST_HALF_DROP: assert property ($fell(half_sec_out) |->
      $changed(time_out.seconds) || $past(wr_ph_ff)) else $error("half bit dropped alone");
   AST_MIN_CARRY: assert property ($changed(time_out.minutes) |-> $past(wr_ph_ff) ||
      ($past(time_out.seconds) == 8'h59 && time_out.seconds == 8'h00))
      else $error("minutes moved without carry");
   AST_DAY_CARRY: assert property ($changed(time_out.day) |-> $past(wr_ph_ff) ||
      ($past(time_out.hours) == 8'h23 && time_out.hours == 8'h00
      && $changed(time_out.weekday))) else $error("day moved without midnight");
   AST_YEAR_CARRY: assert property ($changed(time_out.year) |-> $past(wr_ph_ff) ||
      ($past(time_out.month) == 8'h12 && time_out.month == 8'h01 && time_out.day == 8'h01))
      else $error("year moved without new year");
   COV_YEAR_WRAP: cover property ($past(time_out.year) == 8'h99 && time_out.year == 8'h00);
   COV_HALF_RISE: cover property ($rose(half_sec_out));
   COV_WRITE: cover property (wr_ph_ff);
endmodule

bind bct_timekeeper bct_timekeeper_checker chk (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .htrans_in(htrans_in),
   .hwrite_in(hwrite_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out),
   .hresp_out(hresp_out), .half_sec_out(half_sec_out), .time_out(time_out));

// *** tb/bct_timekeeper_tb.sv ***
// bct_timekeeper_tb: self-checking bench for the bcd calendar timekeeper.
// assumes the checker file is compiled alongside; bench drives all ports.
`timescale 1ns/10ps
module bct_timekeeper_tb;
   typedef struct packed {
      logic [1:0]         sel;
      bct_pkg::bct_time_t start;
      bct_pkg::bct_time_t exp_t;
   } bct_row_t;
   // -----------------------------------------------------------------
   // rollover table: source, start time, time after one second
   // -----------------------------------------------------------------
   localparam bct_row_t ROWS [7] = '{
      '{2'h2, 56'h99123106235959, 56'h00010100000000},
      '{2'h3, 56'h04022803235959, 56'h04022904000000},
      '{2'h2, 56'h01022803235959, 56'h01030104000000},
      '{2'h3, 56'h04043005235959, 56'h04050106000000},
      '{2'h2, 56'h05013101235959, 56'h05020102000000},
      '{2'h3, 56'h05030902090909, 56'h05030902090910},
      '{2'h2, 56'h05063002195959, 56'h05063002200000}};
   logic               ref_clk_in, rst_in, hsel_in, hwrite_in;
   logic               hreadyout_out, hresp_out, half_sec_out;
   logic               xtal_clk_in, xtal_ready_in, mid_clk_in, line_clk_in;
   logic [1:0]         htrans_in, cur_sel;
   logic [31:0]        haddr_in, hwdata_in, hrdata_out, rd;
   bct_pkg::bct_time_t time_out;
   int                 n_errors, tests_run, ratio;

   bct_timekeeper dut (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
      .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
      .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
      .hresp_out(hresp_out), .xtal_clk_in(xtal_clk_in), .xtal_ready_in(xtal_ready_in),
      .mid_clk_in(mid_clk_in), .line_clk_in(line_clk_in), .half_sec_out(half_sec_out),
      .time_out(time_out));

   // 125 mhz bus clock
   initial begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one single ahb transfer; read data taken at the edge ending the data phase
   task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      hsel_in   <= 1'b1;
      htrans_in <= 2'h2;
      haddr_in  <= {24'h0, a};
      hwrite_in <= wr;
      do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
      hsel_in   <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= {24'h0, d};
      do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
      rd = hrdata_out;
   endtask

   // rising edges on the selected source only; the others stand still
   task automatic edges(input int n);
      repeat (n) begin
         @(posedge ref_clk_in);
         xtal_clk_in <= (cur_sel == bct_pkg::SEL_XTAL);
         mid_clk_in  <= (cur_sel == bct_pkg::SEL_MID);
         line_clk_in <= cur_sel[1];
         @(posedge ref_clk_in);
         {xtal_clk_in, mid_clk_in, line_clk_in} <= 3'h0;
      end
      repeat (3) @(posedge ref_clk_in);
   endtask

   // select a source with run and unlock set, then let it settle one edge
   task automatic start_src(input logic [1:0] s);
      cur_sel = s;
      ahb_xfer(1'b1, bct_pkg::OFS_CTRL, {6'h28, s});
      edges(1);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // watchdog: whole run needs about 65k cycles, two long prescaler counts
   initial begin
      repeat (90000) @(posedge ref_clk_in);
      n_errors++;
      finish_test();
   end

   // main sequence
   initial begin
      {rst_in, hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = {1'b1, 68'h0};
      {xtal_clk_in, xtal_ready_in, mid_clk_in, line_clk_in} = 4'h0;
      {n_errors, tests_run, ratio} = '0;
      cur_sel = bct_pkg::SEL_XTAL;
      repeat (16) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      ahb_xfer(1'b0, bct_pkg::OFS_CTRL, 8'h00);
      check("ctrl_rst", rd, 32'h0);
      check("time_rst", time_out, 56'h00010106000000);
      check("half_rst", half_sec_out, 1'b0);
      // unlock first so only the crystal-ready gate can hold the run bit back
      ahb_xfer(1'b1, bct_pkg::OFS_CTRL, 8'h20);
      start_src(bct_pkg::SEL_XTAL);
      ahb_xfer(1'b0, bct_pkg::OFS_CTRL, 8'h00);
      check("run_no_xtal", rd[7], 1'b0);
      xtal_ready_in <= 1'b1;
      // poll run set before any unlock change
      start_src(bct_pkg::SEL_Z50);
      ahb_xfer(1'b0, bct_pkg::OFS_CTRL, 8'h00);
      check("run_on", rd[7], 1'b1);
      $display("test start done");
      foreach (ROWS[i]) begin
         start_src(ROWS[i].sel);
         ratio = (cur_sel == bct_pkg::SEL_Z50) ? 25 : 30;
         // year first, seconds last so the prescaler starts clean
         for (int f = 6; f >= 0; f--) begin
            ahb_xfer(1'b1, 8'(28 - 4 * f), ROWS[i].start[f*8 +: 8]);
         end
         edges(ratio);
         check("half_up", half_sec_out, 1'b1);
         edges(ratio - 1);
         check("sec_hold", time_out, ROWS[i].start);
         ahb_xfer(1'b0, bct_pkg::OFS_CTRL, 8'h00);
         check("warn_up", rd[bct_pkg::CTL_WARN], 1'b1);
         edges(1);
         check("roll", time_out, ROWS[i].exp_t);
         check("half_down", half_sec_out, 1'b0);
         ahb_xfer(1'b0, bct_pkg::OFS_CTRL, 8'h00);
         check("warn_down", rd[bct_pkg::CTL_WARN], 1'b0);
         // every time register read back over the bus
         for (int f = 6; f >= 0; f--) begin
            ahb_xfer(1'b0, 8'(28 - 4 * f), 8'h00);
            check("rd_time", rd, {24'h0, ROWS[i].exp_t[f*8 +: 8]});
         end
         $display("test row %0d done", i);
      end
      for (int s = 0; s < 2; s++) begin
         start_src(2'(s));
         ratio = (s == 0) ? 16384 : 15625;
         ahb_xfer(1'b1, bct_pkg::OFS_SECONDS, 8'h00);
         edges(ratio - 1);
         check("osc_half_lo", half_sec_out, 1'b0);
         edges(1);
         check("osc_half_hi", half_sec_out, 1'b1);
         $display("test source %0d done", s);
      end
      // clear unlock, then writes must bounce off
      ahb_xfer(1'b1, bct_pkg::OFS_CTRL, 8'h81);
      ahb_xfer(1'b1, bct_pkg::OFS_MINUTES, 8'h33);
      // let the landing edge pass before looking
      @(posedge ref_clk_in);
      check("locked_min", time_out.minutes, 8'h00);
      ahb_xfer(1'b1, bct_pkg::OFS_CTRL, 8'h01);
      ahb_xfer(1'b0, bct_pkg::OFS_CTRL, 8'h00);
      check("ctrl_locked", rd, 32'h89);
      ahb_xfer(1'b1, 8'h40, 8'hFF);
      ahb_xfer(1'b0, 8'h40, 8'h00);
      check("unmapped", rd, 32'h0);
      $display("test lock done");
      // mid-run reset brings calendar and control back to reset values
      rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      check("time_rerst", time_out, 56'h00010106000000);
      check("half_rerst", half_sec_out, 1'b0);
      ahb_xfer(1'b0, bct_pkg::OFS_CTRL, 8'h00);
      check("ctrl_rerst", rd, 32'h0);
      $display("test reset done");
      finish_test();
   end
endmodule
